// File: hdl/sdrimb_core.sv
// SDRAM command decode, bank/row tracking, mode load and burst sequencing
//
// Function
// - All inputs except nrst sampled on clock rising edge; nrst resets asynchronously
// - Four banks, 8192 rows, 2048 byte columns
// - ACTIVE latches bank bits and row
// - READ/WRITE take column bits 0-9, 11
// - New column accepted every clock cycle
// - Auto precharge closes row after burst
// - Mode config held until next load
// - Mode fields: BL, type, CL, opmode, WBM
// - Burst length caps locations per command
// - Lengths 1,2,4,8 both types; page sequential
// - Page burst ends on burst terminate
// - Block selected by upper column bits, wraps
// - Lower column bits give start offset
// - Page burst wraps within the row
// - Burst type bit selects ordering
// - Sequential increments; interleaved XORs beat
// - CAS latency two or three clocks
// - Write burst mode bit forces single writes
`timescale 1ns/100ps
module sdrimb_core
  import sdrimb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire sdrimb_pkg::sdrimb_cmd_bus_t cmdIn,
  output sdrimb_pkg::sdrimb_access_t  access,
  output logic                        readData,
  output logic      [NUM_BANKS-1:0]   bankOpen,
  output logic                        modeLoaded,
  output logic                        cmdIllegal
);
  import sdrimb_pkg::*;

  typedef struct packed {
    sdrimb_bstate_t                  bstate;
    logic                            bWrite;
    logic                            bAutoPre;
    logic [BANK_BITS-1:0]            bBank;
    logic [COL_BITS-1:0]             bStart;
    logic [COL_BITS-1:0]             bBeat;
    logic [NUM_BANKS-1:0]            open;
    logic [NUM_BANKS-1:0][ROW_BITS-1:0] rows;
    logic [1:0]                      mrdCnt;
    logic                            loaded;
    logic [1:0]                      rdPipe;
    logic                            rdOut;
    sdrimb_access_t                  acc;
    logic                            illegal;
  } sdrimb_core_state_t;

  sdrimb_core_state_t state;
  sdrimb_core_state_t next_state;

  sdrimb_cmd_t         cmd;
  logic [COL_BITS-1:0] colIn;
  logic [COL_BITS-1:0] colNow;
  logic [COL_BITS-1:0] lastBeat;
  logic [2:0]          burstLength;
  logic                burstType;
  logic [2:0]          casLatency;
  logic [1:0]          opMode;
  logic                writeBurstSingle;
  logic                modeLoad;
  logic                effSingle;

  // Command taken from the pins sampled at this edge
  assign cmd   = cmdIn.csN ? CMD_INHIBIT
                 : sdrimb_cmd_t'({1'b0, cmdIn.rasN, cmdIn.casN, cmdIn.weN});
  // Column is bits 0..9 plus bit 11; bit 10 is the auto precharge flag
  assign colIn = {cmdIn.addr[COL_TOP_PIN],
                  cmdIn.addr[COL_LOW_BITS-1:0]};
  // A load inside recovery is refused, so it must not reach the register
  assign modeLoad = (cmd == CMD_LOADMODE) && (state.open == '0)
                    && (state.bstate == BS_IDLE)
                    && (state.mrdCnt == 2'h0);

  sdrimb_mode_reg i_sdrimb_mode_reg
  (
    .clk              (clk),
    .nrst             (nrst),
    .load             (modeLoad),
    .loadValue        (cmdIn.addr),
    .burstLength      (burstLength),
    .burstType        (burstType),
    .casLatency       (casLatency),
    .opMode           (opMode),
    .writeBurstSingle (writeBurstSingle)
  );

  sdrimb_col_gen i_sdrimb_col_gen
  (
    .startCol    (state.bStart),
    .beat        (state.bBeat),
    .burstLength (burstLength),
    .burstType   (burstType),
    .col         (colNow)
  );

  // Single writes under write burst mode, and length one always
  assign effSingle = (burstLength == BL_ONE) ||
                     (state.bWrite && writeBurstSingle);

  // Last beat index for the programmed length
  always_comb
  begin
    unique case (burstLength)
      BL_TWO:   lastBeat = 11'h001;
      BL_FOUR:  lastBeat = 11'h003;
      BL_EIGHT: lastBeat = 11'h007;
      BL_PAGE:  lastBeat = 11'h7FF;  // Never ends by count
      default:  lastBeat = 11'h000;
    endcase
  end

  // Next state: bank tracking, burst walk, mode recovery
  always_comb
  begin
    next_state         = state;
    next_state.acc     = '0;
    next_state.illegal = 1'b0;
    next_state.rdPipe  = {state.rdPipe[0], 1'b0};
    // Tap one stage early so the strobe itself leaves a flop
    next_state.rdOut   = (casLatency == CL_THREE) ? state.rdPipe[1]
                                                  : state.rdPipe[0];
    if (state.mrdCnt != 2'h0)
    begin
      next_state.mrdCnt = state.mrdCnt - 2'h1;
    end

    // Walk the running burst one column per clock
    if (state.bstate == BS_BURST)
    begin
      next_state.acc = '{valid: 1'b1, write: state.bWrite,
                         bank: state.bBank,
                         row: state.rows[state.bBank], col: colNow};
      next_state.rdPipe[0] = !state.bWrite;
      next_state.bBeat = state.bBeat + 11'h001;
      if (effSingle || (burstLength != BL_PAGE
                        && state.bBeat == lastBeat))
      begin
        next_state.bstate = state.bAutoPre ? BS_AUTOP : BS_IDLE;
      end
    end
    else if (state.bstate == BS_AUTOP)
    begin
      // Self-timed precharge once the burst is over
      next_state.open[state.bBank] = 1'b0;
      next_state.bstate = BS_IDLE;
    end

    // Commands during mode recovery are refused
    if (cmd != CMD_INHIBIT && cmd != CMD_NOP && state.mrdCnt != 2'h0)
    begin
      next_state.illegal = 1'b1;
    end
    else
    begin
      unique case (cmd)
        CMD_ACTIVE:
        begin
          next_state.open[cmdIn.bank] = 1'b1;
          next_state.rows[cmdIn.bank] = cmdIn.addr[ROW_BITS-1:0];
        end
        CMD_READ, CMD_WRITE:
        begin
          // A new column cuts any running burst short
          if (state.open[cmdIn.bank] && state.loaded)
          begin
            next_state.bstate   = BS_BURST;
            next_state.bWrite   = (cmd == CMD_WRITE);
            next_state.bAutoPre = cmdIn.addr[10];
            next_state.bBank    = cmdIn.bank;
            next_state.bStart   = colIn;
            next_state.bBeat    = '0;
          end
          else
          begin
            next_state.illegal = 1'b1;
          end
        end
        CMD_TERMINATE:
        begin
          if (state.bstate == BS_BURST)
          begin
            next_state.bstate = state.bAutoPre ? BS_AUTOP : BS_IDLE;
          end
        end
        CMD_PRECHARGE:
        begin
          if (cmdIn.addr[10])
          begin
            next_state.open = '0;
          end
          else
          begin
            next_state.open[cmdIn.bank] = 1'b0;
          end
        end
        CMD_LOADMODE:
        begin
          if (modeLoad)
          begin
            next_state.loaded = 1'b1;
            next_state.mrdCnt = 2'(MODE_LOAD_RECOVERY_TIME);
          end
          else
          begin
            next_state.illegal = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= '{bstate: BS_IDLE, default: '0};
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from flops; read strobe delayed by CAS latency
  assign access     = state.acc;
  assign readData   = state.rdOut;
  assign bankOpen   = state.open;
  assign modeLoaded = state.loaded;
  assign cmdIllegal = state.illegal;

  sequence s_act;
    cmd == CMD_ACTIVE && state.mrdCnt == 2'h0;
  endsequence

  a_active_opens: assert property (@(posedge clk) disable iff (!nrst)
    s_act |=> state.open[$past(cmdIn.bank)])
    else $error("active did not open bank");
  a_mode_recovery: assert property (@(posedge clk) disable iff (!nrst)
    modeLoad |=> state.mrdCnt == 2'h2 ##1 state.mrdCnt == 2'h1)
    else $error("mode recovery count wrong");
  a_burst_two: assert property (@(posedge clk) disable iff (!nrst)
    (state.bstate == BS_BURST && state.bBeat == 11'h001
     && burstLength == BL_TWO && cmd == CMD_NOP)
    |=> state.bstate != BS_BURST)
    else $error("burst of two overran");
  a_autopre_close: assert property (@(posedge clk) disable iff (!nrst)
    state.bstate == BS_AUTOP && cmd == CMD_NOP
    |=> !state.open[$past(state.bBank)])
    else $error("auto precharge left row open");
  a_wrap_block: assert property (@(posedge clk) disable iff (!nrst)
    state.bstate == BS_BURST && burstLength == BL_FOUR
    |-> (colNow[10:2] == state.bStart[10:2]))
    else $error("burst left its block");
  a_single_write: assert property (@(posedge clk) disable iff (!nrst)
    state.bstate == BS_BURST && state.bWrite && writeBurstSingle
    && cmd == CMD_NOP |=> state.bstate != BS_BURST)
    else $error("write burst not single");
  a_new_column: assert property (@(posedge clk) disable iff (!nrst)
    (cmd == CMD_READ && state.open[cmdIn.bank] && state.loaded
     && state.mrdCnt == 2'h0)
    |=> state.bstate == BS_BURST && state.bBeat == '0)
    else $error("column not accepted");
  a_page_runs: assert property (@(posedge clk) disable iff (!nrst)
    state.bstate == BS_BURST && burstLength == BL_PAGE && !effSingle
    && cmd == CMD_NOP |=> state.bstate == BS_BURST)
    else $error("page burst stopped without terminate");

  // A read beat on the array side, as seen at this edge
  sequence s_read_beat;
    state.acc.valid && !state.acc.write;
  endsequence

  a_read_cl_two: assert property (@(posedge clk) disable iff (!nrst)
    s_read_beat ##0 casLatency == CL_TWO |=> state.rdOut)
    else $error("read strobe missed latency two");
  a_load_refused: assert property (@(posedge clk) disable iff (!nrst)
    cmd == CMD_LOADMODE && state.open != '0 |=> state.illegal)
    else $error("load with open bank not refused");

endmodule : sdrimb_core

// File: shared/sdrimb_pkg.sv
// Shared constants and types for the SDRAM command, mode and burst block
package sdrimb_pkg;

  // Geometry of one component chip
  localparam int BANK_BITS  = 2;
  localparam int ROW_BITS   = 13;
  localparam int COL_BITS   = 11;
  localparam int ADDR_BITS  = 13;
  localparam int NUM_BANKS  = 4;
  localparam int NUM_ROWS   = 8192;
  localparam int NUM_COLS   = 2048;
  localparam int DATA_BITS  = 8;

  // Column pins used for the column: address bits 0..9 and bit 11
  localparam int COL_LOW_BITS = 10;
  localparam int COL_TOP_PIN  = 11;

  // Mode configuration field positions
  localparam int MODE_BITS    = 13;
  localparam int BL_LSB       = 0;
  localparam int BT_POS       = 3;
  localparam int CL_LSB       = 4;
  localparam int OPM_LSB      = 7;
  localparam int WBM_POS      = 9;
  localparam int UNDEF_POS    = 12;

  // Burst length codes
  localparam logic [2:0] BL_ONE   = 3'h0;
  localparam logic [2:0] BL_TWO   = 3'h1;
  localparam logic [2:0] BL_FOUR  = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] BL_PAGE  = 3'h7;

  // CAS latency codes
  localparam logic [2:0] CL_TWO   = 3'h2;
  localparam logic [2:0] CL_THREE = 3'h3;

  // Operating mode: normal
  localparam logic [1:0] OPM_NORMAL = 2'h0;

  // Mode load recovery time, in clocks; config is undefined after reset
  localparam int MODE_LOAD_RECOVERY_TIME = 2;
  localparam logic [12:0] MODE_RESET     = 13'h0000;

  // Command encoding on {csN, rasN, casN, weN}
  typedef enum logic [3:0] {
    CMD_INHIBIT   = 4'h8,
    CMD_NOP       = 4'h7,
    CMD_ACTIVE    = 4'h3,
    CMD_READ      = 4'h5,
    CMD_WRITE     = 4'h4,
    CMD_TERMINATE = 4'h6,
    CMD_PRECHARGE = 4'h2,
    CMD_REFRESH   = 4'h1,
    CMD_LOADMODE  = 4'h0
  } sdrimb_cmd_t;

  // Command bus sample
  typedef struct packed {
    logic                 csN;
    logic                 rasN;
    logic                 casN;
    logic                 weN;
    logic [BANK_BITS-1:0] bank;
    logic [ADDR_BITS-1:0] addr;
  } sdrimb_cmd_bus_t;

  // Burst engine state
  typedef enum logic [1:0] {
    BS_IDLE  = 2'b00,
    BS_BURST = 2'b01,
    BS_AUTOP = 2'b11
  } sdrimb_bstate_t;

  // Column/bank request toward the array
  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic [BANK_BITS-1:0] bank;
    logic [ROW_BITS-1:0]  row;
    logic [COL_BITS-1:0]  col;
  } sdrimb_access_t;

endpackage : sdrimb_pkg

// File: hdl/sdrimb_mode_reg.sv
// Write-only mode configuration register with decoded fields
`timescale 1ns/100ps
module sdrimb_mode_reg
  import sdrimb_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 load,
  input  wire logic [MODE_BITS-1:0] loadValue,
  output logic      [2:0]           burstLength,
  output logic                      burstType,
  output logic      [2:0]           casLatency,
  output logic      [1:0]           opMode,
  output logic                      writeBurstSingle
);
  import sdrimb_pkg::*;

  typedef struct packed {
    logic [MODE_BITS-1:0] cfg;
  } sdrimb_mreg_state_t;

  sdrimb_mreg_state_t state;
  sdrimb_mreg_state_t next_state;

  // Holds until the next load; bit 12 is stored but means nothing
  always_comb
  begin
    next_state = state;
    if (load)
    begin
      next_state.cfg = loadValue;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= '{cfg: MODE_RESET};
    end
    else
    begin
      state <= next_state;
    end
  end

  // Field decode straight off the flops
  assign burstLength      = state.cfg[BL_LSB +: 3];
  assign burstType        = state.cfg[BT_POS];
  assign casLatency       = state.cfg[CL_LSB +: 3];
  assign opMode           = state.cfg[OPM_LSB +: 2];
  assign writeBurstSingle = state.cfg[WBM_POS];

  a_mode_hold: assert property (@(posedge clk) disable iff (!nrst)
    !load |=> $stable(state.cfg))
    else $error("mode config changed without a load");

endmodule : sdrimb_mode_reg

// File: hdl/sdrimb_col_gen.sv
// Burst column address generator: wrap within block, seq or interleave
`timescale 1ns/100ps
module sdrimb_col_gen
  import sdrimb_pkg::*;
(
  input  wire logic [COL_BITS-1:0] startCol,
  input  wire logic [COL_BITS-1:0] beat,
  input  wire logic [2:0]          burstLength,
  input  wire logic                burstType,
  output logic      [COL_BITS-1:0] col
);
  import sdrimb_pkg::*;

  logic [COL_BITS-1:0] mask;
  logic [COL_BITS-1:0] offs;

  // Mask of the in-block bits; page uses the whole row
  always_comb
  begin
    mask = '0;
    unique case (burstLength)
      BL_TWO:   mask = 11'h001;
      BL_FOUR:  mask = 11'h003;
      BL_EIGHT: mask = 11'h007;
      BL_PAGE:  mask = 11'h7FF;
      default:  mask = 11'h000;
    endcase
    // Interleave only for fixed lengths; page is sequential only
    if (burstType && burstLength != BL_PAGE)
    begin
      offs = startCol ^ beat;
    end
    else
    begin
      offs = startCol + beat;
    end
    // Upper bits select the block, lower bits walk within it
    col = (startCol & ~mask) | (offs & mask);
  end

endmodule : sdrimb_col_gen

// File: verification/sdrimb_host_model.sv
// Host memory controller model driving the SDRAM command bus
`timescale 1ns/100ps
module sdrimb_host_model #(
  parameter int POWER_UP_WAIT = 12500
)
(
  input  wire logic                   clk,
  output sdrimb_pkg::sdrimb_cmd_bus_t cmdOut
);
  import sdrimb_pkg::*;

  sdrimb_cmd_bus_t pending [$];

  // Replay on falling edges so the rising edge sees a settled bus
  // Bus is unknown only before the first fall, well inside reset
  always @(negedge clk)
  begin
    if (pending.size() > 0)
      cmdOut <= pending.pop_front();
    else
      cmdOut <= {CMD_NOP, 2'b00, 13'h0000};
  end

  // Queued after a rising edge: never races the replay process
  task automatic issue(input sdrimb_cmd_t c, input logic [1:0] b,
                       input logic [12:0] a);
    @(posedge clk);
    pending.push_back({c, b, a});
  endtask : issue

  // Ends on the falling edge after the last command was taken
  task automatic wait_idle();
    do
      @(posedge clk);
    while (pending.size() > 0);
    @(negedge clk);
  endtask : wait_idle

  // Settle wait, close all banks, then two refreshes
  task automatic power_up();
    repeat (POWER_UP_WAIT) issue(CMD_NOP, 2'b00, 13'h0000);
    issue(CMD_PRECHARGE, 2'b00, 13'h0400);
    repeat (2)
    begin
      issue(CMD_REFRESH, 2'b00, 13'h0000);
      repeat (4) issue(CMD_NOP, 2'b00, 13'h0000);
    end
    wait_idle();
  endtask : power_up

  // Top pin low, normal mode, reserved bits zero, then recovery
  task automatic load_mode(input logic [2:0] bl, input logic bt,
                           input logic [2:0] cl, input logic wbm);
    issue(CMD_LOADMODE, 2'b00,
          {1'b0, 2'b00, wbm, OPM_NORMAL, cl, bt, bl});
    repeat (MODE_LOAD_RECOVERY_TIME)
      issue(CMD_NOP, 2'b00, 13'h0000);
  endtask : load_mode
endmodule : sdrimb_host_model

// File: verification/sdrimb_init_mode_burst_tb.sv
// Self-checking bench for command decode, mode load and burst order
`timescale 1ns/100ps
module sdrimb_init_mode_burst_tb;
  import sdrimb_pkg::*;

  typedef struct packed {
    logic [2:0]  bl;
    logic        bt;
    logic [10:0] start;
    logic [3:0]  beats;
  } sdrimb_row_t;

  localparam logic [12:0] ROW = 13'h1ABC;
  localparam int LIMIT = 16000;
  // Burst cases: mode and start column beside the expected beat count
  localparam sdrimb_row_t ROWS [8] = '{
    '{BL_ONE,   1'b1, 11'h7A5, 4'h1}, '{BL_TWO,   1'b0, 11'h7A5, 4'h2},
    '{BL_TWO,   1'b1, 11'h7A4, 4'h2}, '{BL_FOUR,  1'b0, 11'h7A5, 4'h4},
    '{BL_FOUR,  1'b1, 11'h7A5, 4'h4}, '{BL_EIGHT, 1'b0, 11'h7A3, 4'h8},
    '{BL_EIGHT, 1'b1, 11'h7A5, 4'h8}, '{BL_EIGHT, 1'b1, 11'h7AE, 4'h8}};

  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  sdrimb_cmd_bus_t      cmdBus;
  sdrimb_access_t       access;
  logic                 readData;
  logic [NUM_BANKS-1:0] bankOpen;
  logic                 modeLoaded;
  logic                 cmdIllegal;
  int                   miscompares = 0;
  int                   checked = 0;
  int                   cycles = 0;

  always #4 clk = ~clk;

  sdrimb_core i_sdrimb_core (
    .clk        (clk),
    .nrst       (nrst),
    .cmdIn      (cmdBus),
    .access     (access),
    .readData   (readData),
    .bankOpen   (bankOpen),
    .modeLoaded (modeLoaded),
    .cmdIllegal (cmdIllegal)
  );

  sdrimb_host_model #(.POWER_UP_WAIT(12500)) i_sdrimb_host_model (
    .clk    (clk),
    .cmdOut (cmdBus)
  );

  task automatic print_verdict();
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Hang guard: a run past the ceiling counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_flag

  task automatic cmp_val(input string what, input logic [12:0] exp,
                         input logic [12:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic cmd(input sdrimb_cmd_t c, input logic [1:0] b,
                     input logic [12:0] a);
    i_sdrimb_host_model.issue(c, b, a);
  endtask : cmd

  function automatic logic [12:0] col_addr(input logic [10:0] c,
                                           input logic ap);
    return {c[10], ap, c[9:0]};
  endfunction : col_addr

  // Wrap inside the aligned block; interleave xors the beat in
  function automatic logic [10:0] exp_col(input logic [10:0] s,
    input logic [2:0] bl, input logic bt, input int b);
    logic [10:0] m;
    m = (bl == BL_PAGE) ? 11'h7FF : (11'h001 << bl) - 11'h001;
    return (s & ~m) | ((bt ? (s ^ 11'(b)) : (s + 11'(b))) & m);
  endfunction : exp_col

  task automatic check_reset_outputs();
    cmp_val("idle outputs", 13'h0000, 13'({access.valid, bankOpen,
            modeLoaded, cmdIllegal, readData}));
  endtask : check_reset_outputs

  // Refusals show as a one-cycle pulse within a few cycles
  task automatic expect_illegal();
    logic seen;
    seen = 1'b0;
    for (int w = 0; w < 4; w++)
    begin
      seen = seen | cmdIllegal;
      @(negedge clk);
    end
    cmp_flag("cmdIllegal", 1'b1, seen);
  endtask : expect_illegal

  task automatic setup(input logic [2:0] bl, input logic bt,
    input logic [2:0] cl, input logic wbm, input logic [1:0] bk);
    cmd(CMD_PRECHARGE, 2'b00, 13'h0400);
    cmd(CMD_NOP, 2'b00, 13'h0000);
    i_sdrimb_host_model.load_mode(bl, bt, cl, wbm);
    cmd(CMD_ACTIVE, bk, ROW);
    i_sdrimb_host_model.wait_idle();
    cmp_flag("bankOpen", 1'b1, bankOpen[bk]);
    cmp_flag("modeLoaded", 1'b1, modeLoaded);
  endtask : setup

  task automatic expect_burst(input logic [10:0] s, input logic [2:0] bl,
    input logic bt, input logic wr, input logic [1:0] bk, input int n);
    int w;
    w = 0;
    while (access.valid !== 1'b1 && w < 8)
    begin
      @(negedge clk);
      w++;
    end
    for (int b = 0; b < n; b++)
    begin
      cmp_flag("valid", 1'b1, access.valid);
      cmp_val("col", 13'(exp_col(s, bl, bt, b)), 13'(access.col));
      cmp_val("row", ROW, access.row);
      cmp_val("bank", 13'(bk), 13'(access.bank));
      cmp_flag("write", wr, access.write);
      @(negedge clk);
    end
  endtask : expect_burst

  initial
  begin
    int w;
    int fv;
    int fr;
    int cnt;
    int lat [2];
    repeat (4) @(negedge clk);
    check_reset_outputs();
    nrst <= 1'b1;
    i_sdrimb_host_model.power_up();
    // Access before any mode load is refused
    cmd(CMD_ACTIVE, 2'b00, ROW);
    cmd(CMD_READ, 2'b00, 13'h0000);
    i_sdrimb_host_model.wait_idle();
    expect_illegal();
    // Table of lengths, types and start offsets
    for (int i = 0; i < 8; i++)
    begin
      setup(ROWS[i].bl, ROWS[i].bt, CL_THREE, 1'b0, 2'(i));
      cmd(CMD_READ, 2'(i), col_addr(ROWS[i].start, 1'b0));
      i_sdrimb_host_model.wait_idle();
      expect_burst(ROWS[i].start, ROWS[i].bl, ROWS[i].bt, 1'b0, 2'(i),
                   int'(ROWS[i].beats));
      cmp_flag("valid end", 1'b0, access.valid);
    end
    // Read strobe follows the programmed latency
    for (int k = 0; k < 2; k++)
    begin
      setup(BL_FOUR, 1'b0, k ? CL_THREE : CL_TWO, 1'b0, 2'b01);
      cmd(CMD_READ, 2'b01, col_addr(11'h7A0, 1'b0));
      i_sdrimb_host_model.wait_idle();
      fv = -1;
      fr = -1;
      cnt = 0;
      for (int t = 0; t < 14; t++)
      begin
        if (access.valid === 1'b1 && fv < 0) fv = t;
        if (readData === 1'b1 && fr < 0) fr = t;
        if (readData === 1'b1) cnt++;
        @(negedge clk);
      end
      cmp_val("readData count", 13'h0004, 13'(cnt));
      lat[k] = fr - fv;
    end
    cmp_val("latency step", 13'h0001, 13'(lat[1] - lat[0]));
    cmp_val("read latency", 13'h0001, 13'(lat[0]));
    // A new column cuts the running burst at once
    setup(BL_FOUR, 1'b0, CL_THREE, 1'b0, 2'b01);
    cmd(CMD_READ, 2'b01, col_addr(11'h7A1, 1'b0));
    cmd(CMD_READ, 2'b01, col_addr(11'h7AB, 1'b0));
    i_sdrimb_host_model.wait_idle();
    expect_burst(11'h7A1, BL_FOUR, 1'b0, 1'b0, 2'b01, 1);
    expect_burst(11'h7AB, BL_FOUR, 1'b0, 1'b0, 2'b01, 4);
    // Write bursts with the single-write bit clear and set
    for (int k = 0; k < 2; k++)
    begin
      setup(BL_FOUR, 1'b0, CL_THREE, k[0], 2'b00);
      cmd(CMD_WRITE, 2'b00, col_addr(11'h7A2, 1'b0));
      i_sdrimb_host_model.wait_idle();
      expect_burst(11'h7A2, BL_FOUR, 1'b0, 1'b1, 2'b00, k ? 1 : 4);
      cmp_flag("write end", 1'b0, access.valid);
    end
    // Load with a bank open is refused; old mode stays
    setup(BL_FOUR, 1'b0, CL_THREE, 1'b0, 2'b10);
    cmd(CMD_LOADMODE, 2'b00, 13'h0031);
    i_sdrimb_host_model.wait_idle();
    expect_illegal();
    cmd(CMD_READ, 2'b10, col_addr(11'h7A5, 1'b1));
    i_sdrimb_host_model.wait_idle();
    expect_burst(11'h7A5, BL_FOUR, 1'b0, 1'b0, 2'b10, 4);
    w = 0;
    while (bankOpen[2] !== 1'b0 && w < 4)
    begin
      @(negedge clk);
      w++;
    end
    cmp_flag("auto precharge", 1'b0, bankOpen[2]);
    // Command inside the load recovery window is refused
    cmd(CMD_LOADMODE, 2'b00, 13'h0032);
    cmd(CMD_ACTIVE, 2'b00, ROW);
    i_sdrimb_host_model.wait_idle();
    expect_illegal();
    // Page burst wraps in the row until terminated
    setup(BL_PAGE, 1'b0, CL_THREE, 1'b0, 2'b11);
    cmd(CMD_READ, 2'b11, col_addr(11'h7FE, 1'b0));
    i_sdrimb_host_model.wait_idle();
    expect_burst(11'h7FE, BL_PAGE, 1'b0, 1'b0, 2'b11, 5);
    cmd(CMD_TERMINATE, 2'b00, 13'h0000);
    i_sdrimb_host_model.wait_idle();
    w = 0;
    while (access.valid !== 1'b0 && w < 4)
    begin
      @(negedge clk);
      w++;
    end
    cmp_flag("terminated", 1'b0, access.valid);
    // Read to a closed bank is refused
    cmd(CMD_PRECHARGE, 2'b00, 13'h0400);
    cmd(CMD_READ, 2'b11, 13'h0000);
    i_sdrimb_host_model.wait_idle();
    expect_illegal();
    // Reset in mid-run clears banks and mode state
    nrst <= 1'b0;
    @(negedge clk);
    check_reset_outputs();
    nrst <= 1'b1;
    // Mode is gone after reset, so an access is refused again
    cmd(CMD_ACTIVE, 2'b00, ROW);
    cmd(CMD_READ, 2'b00, 13'h0000);
    i_sdrimb_host_model.wait_idle();
    expect_illegal();
    print_verdict();
  end
endmodule : sdrimb_init_mode_burst_tb
